/* design/low_power_mode_control.sv */
// power-state sequencer: sleep and idle entry, wake-up and clock gating
// assumes the core issues the power-save instruction as a one-cycle strobe
// and that all inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module low_power_mode_control
  import pm_pkg::*;
#(
  parameter int NUM_IRQ = IRQ_COUNT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_save_instruction,
  input wire logic power_save_mode,
  input wire logic [NUM_IRQ-1:0] irq_pending,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic watchdog_timeout,
  input wire logic device_reset_event,
  input wire logic watchdog_enable,
  input wire logic source_is_onchip,
  input wire logic clock_config_locked,
  input wire logic oscillator_control_wr,
  input wire logic [OSC_CTRL_W-1:0] oscillator_control_reg,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic sysclk_source_en,
  output logic onchip_osc_en,
  output logic fail_safe_monitor_en,
  output logic low_power_rc_clock_en,
  output logic watchdog_counter_clear,
  output logic pin_change_notify_en,
  output logic ext_clk_periph_en,
  output logic low_power_active,
  output logic in_sleep,
  output logic in_idle,
  output logic [OSC_SEL_W-1:0] active_osc_select,
  output logic [OSC_SEL_W-1:0] next_oscillator_select
);

  pm_state_t state;
  pm_state_t next_state;

  osc_sel_if sel_bus ();

  // state decode
  wire st_run = (state == ST_RUN);
  wire st_idle = (state == ST_IDLE);
  wire st_prep = (state == ST_PREP);
  wire st_sleep = (state == ST_SLEEP);

  // wake-up sources; a pending interrupt only counts while its own enable is set
  wire [NUM_IRQ-1:0] irq_hit;
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq_hit
    assign irq_hit[i] = irq_pending[i] && irq_enable[i];
  end
  wire irq_wake = |irq_hit;
  wire wake_event = irq_wake || watchdog_timeout || device_reset_event;

  wire enter_req = power_save_instruction && st_run;
  wire enter_sleep = enter_req && (power_save_mode == MODE_SLEEP);
  wire enter_idle = enter_req && (power_save_mode == MODE_IDLE);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (enter_sleep) begin
          next_state = ST_PREP;
        end else if (enter_idle) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wake_event) begin
          next_state = ST_RUN;
        end
      end
      // one cycle for the watchdog clear before the peripheral and source clocks stop (the cpu clock is already off);
      // a wake in this cycle aborts the entry instead of being lost
      ST_PREP: begin
        if (wake_event) begin
          next_state = ST_RUN;
        end else begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_event) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // output decode from the next state so every output is a flop
  // that changes on the same edge as the state
  wire nx_sleep = (next_state == ST_SLEEP);
  wire nx_prep = (next_state == ST_PREP);
  wire nx_idle = (next_state == ST_IDLE);
  wire nx_low = nx_sleep || nx_prep || nx_idle;

  wire next_cpu_clk_en = !nx_low;
  wire next_periph_clk_en = !nx_sleep;
  wire next_sysclk_source_en = !nx_sleep;
  wire next_onchip_osc_en = !(nx_sleep && source_is_onchip);
  wire next_fail_safe_monitor_en = !nx_sleep;
  wire next_low_power_rc_clock_en = !nx_sleep || watchdog_enable;
  wire next_watchdog_counter_clear = nx_prep && watchdog_enable;
  // change notification and external-clock peripherals never gated
  wire next_ext_en = 1'h1;
  wire next_low_power_active = nx_low;
  wire next_in_sleep = nx_sleep || nx_prep;
  wire next_in_idle = nx_idle;

  // one short flop per output, so each output is a plain register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_clk_en <= 1'h1;
    end else begin
      cpu_clk_en <= next_cpu_clk_en;
    end
  end

  // idle keeps this running so peripherals go on working
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periph_clk_en <= 1'h1;
    end else begin
      periph_clk_en <= next_periph_clk_en;
    end
  end

  // gated only after the prep cycle, so the watchdog clear still sees a clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sysclk_source_en <= 1'h1;
    end else begin
      sysclk_source_en <= next_sysclk_source_en;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      onchip_osc_en <= 1'h1;
    end else begin
      onchip_osc_en <= next_onchip_osc_en;
    end
  end

  // a live monitor would flag the stopped source as a clock failure
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fail_safe_monitor_en <= 1'h1;
    end else begin
      fail_safe_monitor_en <= next_fail_safe_monitor_en;
    end
  end

  // the watchdog counts on this clock, so it may not stop under it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_power_rc_clock_en <= 1'h1;
    end else begin
      low_power_rc_clock_en <= next_low_power_rc_clock_en;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watchdog_counter_clear <= 1'h0;
    end else begin
      watchdog_counter_clear <= next_watchdog_counter_clear;
    end
  end

  // wake sources of their own; gating them would leave no way out of sleep
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_change_notify_en <= 1'h1;
    end else begin
      pin_change_notify_en <= next_ext_en;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_clk_periph_en <= 1'h1;
    end else begin
      ext_clk_periph_en <= next_ext_en;
    end
  end

  // single indication to the clock gate; drops on the edge after the wake
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_power_active <= 1'h0;
    end else begin
      low_power_active <= next_low_power_active;
    end
  end

  // prep counts as sleep, so the gate never sees a run gap between them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_sleep <= 1'h0;
    end else begin
      in_sleep <= next_in_sleep;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_idle <= 1'h0;
    end else begin
      in_idle <= next_in_idle;
    end
  end

  // clock source selection
  assign sel_bus.wr = oscillator_control_wr;
  assign sel_bus.wr_sel = oscillator_control_reg[OSC_SEL_MSB:OSC_SEL_LSB];
  assign sel_bus.locked = clock_config_locked;
  assign sel_bus.hold = st_sleep || st_prep;

  osc_select_keeper u_keeper (
    .clk(clk),
    .nrst(nrst),
    .sel(sel_bus.keeper)
  );

  assign active_osc_select = sel_bus.active_sel;
  assign next_oscillator_select = sel_bus.pending_sel;

endmodule

`default_nettype wire

/* design/osc_sel_if.sv */
// signals between the power-state sequencer and the oscillator select keeper
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none

interface osc_sel_if;
  import pm_pkg::*;
  logic wr;
  logic [OSC_SEL_W-1:0] wr_sel;
  logic locked;
  logic hold;
  logic [OSC_SEL_W-1:0] active_sel;
  logic [OSC_SEL_W-1:0] pending_sel;

  modport ctrl (output wr, output wr_sel, output locked, output hold,
                input active_sel, input pending_sel);
  modport keeper (input wr, input wr_sel, input locked, input hold,
                  output active_sel, output pending_sel);
endinterface

`default_nettype wire

/* design/osc_select_keeper.sv */
// holds the requested and the active system clock source selection
// assumes writes arrive as one-cycle strobes from the sequencer
`timescale 1ns/1ps
`default_nettype none

module osc_select_keeper
  import pm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  osc_sel_if.keeper sel
);

  wire take_write = sel.wr && !sel.locked;
  // a pending switch waits while asleep so the wake-up source is unchanged
  wire do_switch = !sel.hold && (sel.pending_sel != sel.active_sel);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel.pending_sel <= OSC_SEL_RESET;
    end else if (take_write) begin
      sel.pending_sel <= sel.wr_sel;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel.active_sel <= OSC_SEL_RESET;
    end else if (do_switch) begin
      sel.active_sel <= sel.pending_sel;
    end
  end

endmodule

`default_nettype wire

/* design/pm_pkg.sv */
// constants and types for the low-power mode controller
// assumes a single 25 MHz clock domain; no software-visible registers here
package pm_pkg;

  // operand of the power-save instruction
  localparam logic MODE_SLEEP = 1'h0;
  localparam logic MODE_IDLE = 1'h1;

  // new-oscillator select field of the oscillator control word
  localparam int OSC_SEL_W = 3;
  localparam int OSC_SEL_LSB = 8;
  localparam int OSC_SEL_MSB = 10;
  localparam int OSC_CTRL_W = 16;
  localparam logic [2:0] OSC_SEL_RESET = 3'h0;

  // default number of individually enabled interrupt sources
  localparam int IRQ_COUNT = 8;

  // power state, one-hot
  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_IDLE  = 4'h2,
    ST_PREP  = 4'h4,
    ST_SLEEP = 4'h8
  } pm_state_t;

endpackage

/* test/cpu_core_model.sv */
// core model issuing the power-save instruction
// assumes callers sit at a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic clk,
  output logic power_save_instruction,
  output logic power_save_mode
);
  initial {power_save_instruction, power_save_mode} = 2'h0;
  // one-cycle strobe, operand picks the mode
  task automatic exec(input logic m);
    power_save_mode = m;
    power_save_instruction = 1'b1;
    @(negedge clk);
    power_save_instruction = 1'b0;
    power_save_mode = ~m;
  endtask
endmodule
`default_nettype wire

/* test/low_power_mode_control_test.sv */
// self-checking bench for the low-power mode controller
// assumes the core model drives the instruction strobe
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_control_test;
  import pm_pkg::*;
  logic clk, nrst, power_save_instruction, power_save_mode, watchdog_timeout;
  logic device_reset_event, watchdog_enable, source_is_onchip, clock_config_locked;
  logic oscillator_control_wr, cpu_clk_en, periph_clk_en, sysclk_source_en, onchip_osc_en;
  logic fail_safe_monitor_en, low_power_rc_clock_en, watchdog_counter_clear;
  logic pin_change_notify_en, ext_clk_periph_en, low_power_active, in_sleep, in_idle;
  logic [7:0] irq_pending, irq_enable;
  logic [15:0] oscillator_control_reg;
  logic [2:0] active_osc_select, next_oscillator_select;
  int n_fail = 0;
  int cmp_count = 0;
  // mode, wake kind, watchdog enable, on-chip source | clear pulse, outputs in low power
  logic [14:0] rows [6] = '{15'h417d, 15'h517d, 15'h617d, 15'h0f06, 15'h1b16, 15'h2502};
  logic [14:0] r;
  wire [8:0] outs = {pin_change_notify_en, cpu_clk_en, periph_clk_en, sysclk_source_en,
    onchip_osc_en, fail_safe_monitor_en, low_power_rc_clock_en, in_sleep, in_idle};
  low_power_mode_control i_dut (.clk, .nrst, .power_save_instruction, .power_save_mode,
    .irq_pending, .irq_enable, .watchdog_timeout, .device_reset_event, .watchdog_enable,
    .source_is_onchip, .clock_config_locked, .oscillator_control_wr, .oscillator_control_reg,
    .cpu_clk_en, .periph_clk_en, .sysclk_source_en, .onchip_osc_en, .fail_safe_monitor_en,
    .low_power_rc_clock_en, .watchdog_counter_clear, .pin_change_notify_en, .ext_clk_periph_en,
    .low_power_active, .in_sleep, .in_idle, .active_osc_select, .next_oscillator_select);
  cpu_core_model i_cpu (.clk, .power_save_instruction, .power_save_mode);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input string s, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wake(input logic [1:0] k);
    irq_pending = 8'(k == 2'h0) << 2;
    watchdog_timeout = k == 2'h1;
    device_reset_event = k == 2'h2;
    @(negedge clk);
    {irq_pending, watchdog_timeout, device_reset_event} = 10'h0;
  endtask
  // released data turns over so a stale field cannot pass
  task osc_write(input logic [2:0] v);
    oscillator_control_wr = 1'b1;
    oscillator_control_reg = {5'h0, v, 8'h0};
    @(negedge clk);
    oscillator_control_wr = 1'b0;
    oscillator_control_reg = ~oscillator_control_reg;
  endtask
  initial begin
    nrst = 1'b0;
    {irq_pending, watchdog_timeout, device_reset_event, watchdog_enable} = 11'h0;
    {source_is_onchip, clock_config_locked, oscillator_control_wr} = 3'h0;
    oscillator_control_reg = 16'h0;
    irq_enable = 8'h04;
    repeat (6) @(negedge clk);
    chk("reset", 9'h1fc, outs);
    nrst = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      {watchdog_enable, source_is_onchip} = r[11:10];
      i_cpu.exec(r[14]);
      chk("clear", 9'(r[9]), 9'(watchdog_counter_clear));
      @(negedge clk);
      chk("lp", r[8:0], outs);
      chk("ext", 9'h1, 9'(ext_clk_periph_en));
      chk("clear_end", 9'h0, 9'(watchdog_counter_clear));
      irq_pending = 8'h20;
      @(negedge clk);
      chk("masked", 9'h1, 9'(low_power_active));
      wake(r[13:12]);
      chk("wake", 9'h1fc, outs);
    end
    clock_config_locked = 1'b1;
    osc_write(3'h5);
    chk("locked", 9'h0, 9'(next_oscillator_select));
    clock_config_locked = 1'b0;
    @(negedge clk);
    osc_write(3'h5);
    chk("select", 9'h5, 9'(next_oscillator_select));
    @(negedge clk);
    chk("active", 9'h5, 9'(active_osc_select));
    i_cpu.exec(MODE_SLEEP);
    osc_write(3'h3);
    repeat (3) @(negedge clk);
    chk("kept", 9'h5, 9'(active_osc_select));
    wake(2'h1);
    i_cpu.exec(MODE_IDLE);
    chk("resumed", 9'h3, 9'(active_osc_select));
    nrst = 1'b0;
    @(negedge clk);
    chk("reset2", 9'h1fc, outs);
    nrst = 1'b1;
    @(negedge clk);
    results;
  end
  initial begin
    #50000;
    n_fail++;
    results;
  end
endmodule
`default_nettype wire

/* test/lpm_checker.sv */
// port assertions for the low-power mode controller
// assumes one clock domain, nrst async active low
`timescale 1ns/1ps
`default_nettype none
module lpm_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic power_save_instruction,
  input wire logic power_save_mode,
  input wire logic watchdog_timeout,
  input wire logic device_reset_event,
  input wire logic watchdog_enable,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic sysclk_source_en,
  input wire logic fail_safe_monitor_en,
  input wire logic low_power_rc_clock_en,
  input wire logic watchdog_counter_clear,
  input wire logic low_power_active,
  input wire logic in_sleep,
  input wire logic in_idle,
  input wire logic [2:0] active_osc_select
);
  wire go = power_save_instruction && !low_power_active;
  wire wake = watchdog_timeout || device_reset_event;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_IDLE_IN: assert property (go && power_save_mode |=> in_idle && !cpu_clk_en && periph_clk_en)
    else $error("idle entry");
  AST_SLEEP_IN: assert property (go && !power_save_mode |=> in_sleep && !cpu_clk_en)
    else $error("sleep entry");
  AST_WDT_CLR: assert property (go && !power_save_mode && watchdog_enable |=> watchdog_counter_clear)
    else $error("watchdog clear");
  AST_SRC_OFF: assert property ($rose(in_sleep) ##1 in_sleep |-> !sysclk_source_en && !periph_clk_en)
    else $error("source still on");
  AST_MON: assert property ($rose(in_sleep) ##1 in_sleep |-> !fail_safe_monitor_en && low_power_rc_clock_en == watchdog_enable)
    else $error("monitor or rc");
  AST_WAKE: assert property (low_power_active && wake |=> !low_power_active && cpu_clk_en)
    else $error("no wake");
  AST_NO_ENTRY: assert property (!power_save_instruction && !low_power_active |=> !low_power_active)
    else $error("entry without strobe");
  AST_SRC_KEPT: assert property (in_sleep ##1 in_sleep |-> $stable(active_osc_select))
    else $error("source moved in sleep");
  COV_IDLE: cover property (go && power_save_mode);
  COV_SLEEP: cover property ($rose(in_sleep) ##1 in_sleep);
  COV_WAKE: cover property (in_sleep && wake);
endmodule
bind low_power_mode_control lpm_checker i_chk (.clk, .nrst, .power_save_instruction,
  .power_save_mode, .watchdog_timeout, .device_reset_event, .watchdog_enable, .cpu_clk_en,
  .periph_clk_en, .sysclk_source_en, .fail_safe_monitor_en, .low_power_rc_clock_en,
  .watchdog_counter_clear, .low_power_active, .in_sleep, .in_idle, .active_osc_select);
`default_nettype wire
